// file: core/mpwm_consts.svh
// constants for the multi-channel pwm generator with fault brake
// What this block does
// [RULE1] counter clock: system or timer overflow, prescaled
// [RULE2] shared counter and period, independent duty values
// [RULE3] group mode: channels follow duty 0 or 1
// [RULE4] mode, dead-time, mask, brake, polarity, pin mux
// [RULE5] software clears counter, loads values, then runs
// [RULE6] period and duty double buffered, load at end
// [RULE7] software waits for load bit to clear
// [RULE8] edge type: count zero to period, restart
// [RULE9] edge type: frequency over period plus one
// [RULE10] center type: count up then down
// [RULE11] center type: frequency over twice the period
// [RULE12] mode field: independent, complementary, synchronous
// [RULE13] complementary: odd channel inverts even neighbour
// [RULE14] dead-time counter delays rising edges per pair
// [RULE15] per-pair enable, complementary main only, unlocked
// [RULE16] synchronous: odd channel copies even neighbour
// [RULE17] mask enable replaces signal with mask level
// [RULE18] brake: brake data, stop, clear counter, flag
// [RULE19] brake pin edge select, eight clock debounce
// [RULE20] per-channel polarity inversion on main outputs
// [RULE21] period flag at selected channel and point
// [RULE22] brake flag gated onto its own interrupt
`ifndef MPWM_CONSTS_SVH
`define MPWM_CONSTS_SVH
`define MPWM_CNT_RST      16'h0000
`define MPWM_SRC_SYS      1'h0
`define MPWM_SRC_T1       1'h1
`define MPWM_SEL_PERIOD   3'h7
`define MPWM_PT_FALL      2'h0
`define MPWM_PT_RISE      2'h1
`define MPWM_PT_CENTER    2'h2
`define MPWM_PT_END       2'h3
`define MPWM_DEBOUNCE_MAX 3'h7
`define MPWM_DT_RST       9'h000
`define MPWM_DTEN_RST     4'h0
`endif

// file: core/mpwm_pkg.sv
// types shared by the pwm generator files
package mpwm_pkg;
	typedef logic [15:0] mpwm_word_t;
	typedef enum logic [1:0] {MPWM_INDEP, MPWM_COMPL, MPWM_SYNC,
		MPWM_RSVD} mpwm_mode_e;
	typedef struct packed {
		logic       valid;
		logic [1:0] inst;
		logic [2:0] sel;
		mpwm_word_t data;
	} mpwm_write_s;
	typedef struct packed {
		logic       alignCenter;
		mpwm_mode_e outMode;
		logic       groupMode;
		logic [5:0] maskEn;
		logic [5:0] maskLvl;
		logic [2:0] eventChannel;
		logic [1:0] eventPoint;
	} mpwm_cfg_s;
	typedef struct packed {
		logic [5:0] polarity;
		logic [5:0] brakeData;
		logic       brakeEdge;
		logic       brakeInEnable;
		logic       brakeIrqEnable;
	} mpwm_main_s;
endpackage

// file: core/mpwm_deadtime.sv
// dead-time insertion for one complementary pair
`timescale 1ns/1ps
module mpwm_deadtime #(
	parameter int DT_W = 9
)(
	input  logic            clk_sys,
	input  logic            rst,
	input  logic            enable,
	input  logic [DT_W-1:0] count,
	input  logic            inA,
	input  logic            inB,
	output logic            outA,
	output logic            outB
);
	logic            prevA_reg;
	logic            prevB_reg;
	logic [DT_W-1:0] cnt_reg;
	logic            done_reg;
	logic            rise;

	assign rise = (inA & ~prevA_reg) | (inB & ~prevB_reg);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prevA_reg <= 1'b0;
			prevB_reg <= 1'b0;
		end else begin
			prevA_reg <= inA;
			prevB_reg <= inB;
		end
	end

	// a new rising edge reloads, so both sides stay off for the full gap
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_reg  <= '0;
			done_reg <= 1'b1;
		end else if (rise) begin
			cnt_reg  <= count; // [RULE14]
			done_reg <= 1'b0;
		end else if (!done_reg) begin
			if (cnt_reg == '0)
				done_reg <= 1'b1; // [RULE14]
			else
				cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign outA = enable ? (inA & done_reg & ~rise) : inA; // [RULE14]
	assign outB = enable ? (inB & done_reg & ~rise) : inB; // [RULE14]

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_dt_hold;
		enable && rise |=> !outA && !outB;
	endproperty
	a_dt_hold: assert property (p_dt_hold) // [RULE14]
		else $error("dead-time gap missing after rising edge");
endmodule // mpwm_deadtime

// file: core/mpwm_debounce.sv
// brake pin debounce and edge detection
`timescale 1ns/1ps
`include "mpwm_consts.svh"
module mpwm_debounce (
	input  logic clk_sys,
	input  logic rst,
	input  logic pin,
	input  logic edgeSel,
	output logic event_reg
);
	logic       filt_reg;
	logic [2:0] cnt_reg;
	logic       flip;

	assign flip = (pin != filt_reg) && (cnt_reg == `MPWM_DEBOUNCE_MAX);

	// a level must differ for eight clocks in a row before it counts
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			filt_reg <= 1'b0;
			cnt_reg  <= 3'h0;
		end else if (pin == filt_reg) begin
			cnt_reg <= 3'h0;
		end else if (flip) begin
			filt_reg <= pin; // [RULE19]
			cnt_reg  <= 3'h0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			event_reg <= 1'b0;
		else
			event_reg <= flip && (pin == edgeSel); // [RULE19]
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_db_stable;
		event_reg |-> $past(pin, 1) == $past(pin, 8);
	endproperty
	a_db_stable: assert property (p_db_stable) // [RULE19]
		else $error("brake event without eight stable samples");
endmodule // mpwm_debounce

// file: core/mpwm_top.sv
// four pwm generator instances; dead-time and fault brake act on the main instance only
`timescale 1ns/1ps
`include "mpwm_consts.svh"
module mpwm_top #(
	parameter int NINST = 4,
	parameter int NCH   = 6,
	parameter int NPAIR = 3,
	parameter int DT_W  = 9
)(
	input  logic                     clk_sys,
	input  logic                     rst,
	input  logic                     clockSource,
	input  logic [2:0]               clockPrescale,
	input  logic                     timer1Overflow,
	input  mpwm_pkg::mpwm_write_s    wr,
	input  logic [NINST-1:0]         runSet,
	input  logic [NINST-1:0]         runClear,
	input  logic [NINST-1:0]         loadSet,
	input  logic [NINST-1:0]         clearSet,
	input  logic [NINST-1:0]         periodFlagClear,
	input  logic                     brakeFlagClear,
	input  mpwm_pkg::mpwm_cfg_s      cfg [NINST],
	input  mpwm_pkg::mpwm_main_s     mainCfg,
	input  logic                     deadtimeWrite,
	input  logic                     timedAccessUnlock,
	input  logic [DT_W-1:0]          deadtimeCountIn,
	input  logic [3:0]               deadtimeEnableIn,
	input  logic                     brakeInputPin,
	input  logic                     adcCompareEvent,
	input  logic [NCH-1:0]           pwmSelect [NINST],
	input  logic [NCH-1:0]           gpioData [NINST],
	output logic [NCH-1:0]           pinOut_reg [NINST],
	output logic [NINST-1:0]         runState_reg,
	output logic [NINST-1:0]         loadPending_reg,
	output logic [NINST-1:0]         clearPending_reg,
	output logic [NINST-1:0]         periodEventFlag_reg,
	output logic                     brakeFlag_reg,
	output logic                     brakeIrq_reg
);
	logic [6:0]               pre_reg;
	logic [7:0]               divShift;
	logic [6:0]               divMax;
	logic                     srcPulse;
	logic                     tick;
	mpwm_pkg::mpwm_word_t     cnt_reg [NINST];
	logic [NINST-1:0]         countDown_reg;
	mpwm_pkg::mpwm_word_t     periodBuf_reg [NINST];
	mpwm_pkg::mpwm_word_t     periodAct_reg [NINST];
	mpwm_pkg::mpwm_word_t     dutyBuf_reg [NINST][NCH];
	mpwm_pkg::mpwm_word_t     dutyAct_reg [NINST][NCH];
	logic [NINST-1:0]         atEnd;
	logic [NINST-1:0]         loadNow;
	logic [NINST-1:0]         dutyHit;
	logic [NINST-1:0]         pointHit;
	logic [NCH-1:0]           gen [NINST];
	logic [NCH-1:0]           modeOut [NINST];
	logic [NCH-1:0]           dtMain;
	logic [NCH-1:0]           pinNext [NINST];
	logic [DT_W-1:0]          dtCount_reg;
	logic [3:0]               dtEnable_reg;
	logic                     brakeActive_reg;
	logic                     pinEvent;
	logic                     brakeEvent;

	function automatic int chanCount(input int inst);
		return (inst == 0) ? NCH : 2;
	endfunction

	// group mode folds the main instance onto the first two duty values
	function automatic int dutyIndex(input int inst, input int ch,
		input logic group);
		return (inst == 0 && group) ? (ch % 2) : ch; // [RULE3]
	endfunction

	// prescaler: one pwm tick every 2**code source pulses
	assign divShift = 8'h01 << clockPrescale;
	assign divMax   = divShift[6:0] - 7'h01;
	assign srcPulse = (clockSource == `MPWM_SRC_T1) ? timer1Overflow : 1'b1;
	// a smaller code taken mid-count must not wait for the wrap at 127
	assign tick     = srcPulse && (pre_reg >= divMax); // [RULE1]

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pre_reg <= 7'h00;
		else if (srcPulse)
			pre_reg <= tick ? 7'h00 : pre_reg + 7'h01; // [RULE1]
	end

	mpwm_debounce u_debounce (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pin       (brakeInputPin),
		.edgeSel   (mainCfg.brakeEdge),
		.event_reg (pinEvent)
	);
	// the compare path takes the same action as the pin
	assign brakeEvent = (pinEvent && mainCfg.brakeInEnable)
		|| adcCompareEvent; // [RULE19]

	always_comb begin
		for (int i = 0; i < NINST; i++) begin
			if (cfg[i].alignCenter)
				atEnd[i] = countDown_reg[i] && cnt_reg[i] == '0;
			else
				atEnd[i] = cnt_reg[i] == periodAct_reg[i];
			// idle instances take new values at once
			loadNow[i] = loadPending_reg[i]
				&& (!runState_reg[i] || (tick && atEnd[i])); // [RULE6]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			runState_reg    <= '0;
			brakeActive_reg <= 1'b0;
		end else begin
			runState_reg <= (runState_reg | runSet) & ~runClear;
			if (brakeEvent) begin
				runState_reg[0] <= 1'b0; // [RULE18]
				brakeActive_reg <= 1'b1; // [RULE18]
			end else if (runSet[0]) begin
				brakeActive_reg <= 1'b0; // [RULE18]
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clearPending_reg <= '0;
			loadPending_reg  <= '0;
		end else begin
			clearPending_reg <= clearSet;
			loadPending_reg  <= loadSet | (loadPending_reg & ~loadNow); // [RULE6]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NINST; i++) begin
				cnt_reg[i]       <= `MPWM_CNT_RST;
				countDown_reg[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < NINST; i++) begin
				if (clearPending_reg[i] || (i == 0 && brakeEvent)) begin
					cnt_reg[i]       <= `MPWM_CNT_RST; // [RULE18]
					countDown_reg[i] <= 1'b0;
				end else if (tick && runState_reg[i]) begin
					if (!cfg[i].alignCenter) begin
						countDown_reg[i] <= 1'b0;
						cnt_reg[i] <= atEnd[i] ? `MPWM_CNT_RST
							: cnt_reg[i] + 16'h0001; // [RULE8] [RULE9]
					end else if (!countDown_reg[i]) begin
						if (cnt_reg[i] >= periodAct_reg[i]) begin
							countDown_reg[i] <= 1'b1; // [RULE10]
							cnt_reg[i] <= (cnt_reg[i] == '0) ? cnt_reg[i]
								: cnt_reg[i] - 16'h0001; // [RULE11]
						end else begin
							cnt_reg[i] <= cnt_reg[i] + 16'h0001;
						end
					end else if (cnt_reg[i] == '0) begin
						countDown_reg[i] <= 1'b0; // [RULE10]
						cnt_reg[i] <= (periodAct_reg[i] == '0) ? cnt_reg[i]
							: cnt_reg[i] + 16'h0001;
					end else begin
						cnt_reg[i] <= cnt_reg[i] - 16'h0001;
					end
				end
			end
		end
	end

	// software may write buffers any time; active copies move on load
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NINST; i++) begin
				periodBuf_reg[i] <= '0;
				periodAct_reg[i] <= '0;
				for (int c = 0; c < NCH; c++) begin
					dutyBuf_reg[i][c] <= '0;
					dutyAct_reg[i][c] <= '0;
				end
			end
		end else begin
			for (int i = 0; i < NINST; i++) begin
				if (wr.valid && wr.inst == 2'(i)) begin
					if (wr.sel == `MPWM_SEL_PERIOD)
						periodBuf_reg[i] <= wr.data; // [RULE6]
					else if (int'(wr.sel) < chanCount(i))
						dutyBuf_reg[i][wr.sel] <= wr.data; // [RULE2]
				end
				if (loadNow[i]) begin
					periodAct_reg[i] <= periodBuf_reg[i]; // [RULE6]
					for (int c = 0; c < NCH; c++)
						dutyAct_reg[i][c] <= dutyBuf_reg[i][c];
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NINST; i++) begin
			dutyHit[i] = 1'b0;
			for (int c = 0; c < NCH; c++) begin
				// high below the duty value; cleared on match, set at zero in edge type
				gen[i][c] = c < chanCount(i) && cnt_reg[i]
					< dutyAct_reg[i][dutyIndex(i, c, cfg[i].groupMode)]; // [RULE2]
				if (c < chanCount(i) && int'(cfg[i].eventChannel) == c
					&& cnt_reg[i]
					== dutyAct_reg[i][dutyIndex(i, c, cfg[i].groupMode)])
					dutyHit[i] = 1'b1;
			end
			for (int c = 0; c < NCH; c++) begin
				if (c % 2 == 0 || c >= chanCount(i))
					modeOut[i][c] = gen[i][c];
				else
					case (cfg[i].outMode)
						mpwm_pkg::MPWM_COMPL: modeOut[i][c] = ~gen[i][c-1]; // [RULE13]
						mpwm_pkg::MPWM_SYNC:  modeOut[i][c] = gen[i][c-1]; // [RULE16]
						default:              modeOut[i][c] = gen[i][c]; // [RULE12]
					endcase
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dtCount_reg  <= `MPWM_DT_RST;
			dtEnable_reg <= `MPWM_DTEN_RST;
		end else if (deadtimeWrite && timedAccessUnlock) begin
			dtCount_reg  <= deadtimeCountIn; // [RULE15]
			dtEnable_reg <= deadtimeEnableIn; // [RULE15]
		end
	end

	for (genvar p = 0; p < NPAIR; p++) begin : g_pair
		mpwm_deadtime #(.DT_W(DT_W)) u_dt (
			.clk_sys (clk_sys),
			.rst     (rst),
			.enable  (dtEnable_reg[p]
				&& cfg[0].outMode == mpwm_pkg::MPWM_COMPL), // [RULE15]
			.count   (dtCount_reg),
			.inA     (modeOut[0][2*p]),
			.inB     (modeOut[0][2*p+1]),
			.outA    (dtMain[2*p]),
			.outB    (dtMain[2*p+1])
		);
	end

	// stage order: mode, dead-time, mask, brake, polarity, pin mux
	always_comb begin
		for (int i = 0; i < NINST; i++) begin
			for (int c = 0; c < NCH; c++) begin
				pinNext[i][c] = (i == 0) ? dtMain[c] : modeOut[i][c];
				if (cfg[i].maskEn[c])
					pinNext[i][c] = cfg[i].maskLvl[c]; // [RULE17]
				if (i == 0 && brakeActive_reg)
					pinNext[i][c] = mainCfg.brakeData[c]; // [RULE18]
				if (i == 0)
					pinNext[i][c] = pinNext[i][c] ^ mainCfg.polarity[c]; // [RULE20]
				// run alone never takes the pin; the select does
				if (!pwmSelect[i][c])
					pinNext[i][c] = gpioData[i][c]; // [RULE4]
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NINST; i++)
				pinOut_reg[i] <= '0;
		end else begin
			for (int i = 0; i < NINST; i++)
				pinOut_reg[i] <= pinNext[i]; // [RULE4]
		end
	end

	always_comb begin
		for (int i = 0; i < NINST; i++) begin
			case (cfg[i].eventPoint)
				`MPWM_PT_FALL: pointHit[i] = !countDown_reg[i] && dutyHit[i];
				`MPWM_PT_RISE: pointHit[i] = cfg[i].alignCenter
					? countDown_reg[i] && dutyHit[i] : cnt_reg[i] == '0;
				`MPWM_PT_CENTER: pointHit[i] = cfg[i].alignCenter
					&& !countDown_reg[i]
					&& cnt_reg[i] == periodAct_reg[i]; // [RULE21]
				`MPWM_PT_END: pointHit[i] = cfg[i].alignCenter
					&& countDown_reg[i] && cnt_reg[i] == '0; // [RULE21]
				default: pointHit[i] = 1'b0;
			endcase
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			periodEventFlag_reg <= '0;
			brakeFlag_reg       <= 1'b0;
			brakeIrq_reg        <= 1'b0;
		end else begin
			periodEventFlag_reg <= ({NINST{tick}} & runState_reg & pointHit)
				| (periodEventFlag_reg & ~periodFlagClear); // [RULE21]
			brakeFlag_reg <= brakeEvent
				| (brakeFlag_reg & ~brakeFlagClear); // [RULE18]
			brakeIrq_reg <= brakeFlag_reg && mainCfg.brakeIrqEnable; // [RULE22]
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_brake_done;
		!runState_reg[0] && cnt_reg[0] == '0 && brakeFlag_reg;
	endsequence
	property p_brake;
		brakeEvent |=> s_brake_done ##1 brakeActive_reg;
	endproperty
	a_brake: assert property (p_brake) // [RULE18]
		else $error("brake did not stop and flag the main instance");

	property p_load;
		loadPending_reg[0] && runState_reg[0] && tick && atEnd[0]
			&& !loadSet[0] |=> !loadPending_reg[0]
			&& periodAct_reg[0] == $past(periodBuf_reg[0]);
	endproperty
	a_load: assert property (p_load) // [RULE6]
		else $error("buffered period not taken at period end");

	property p_edge_wrap;
		!cfg[0].alignCenter && runState_reg[0] && tick && atEnd[0]
			&& !clearPending_reg[0] |=> cnt_reg[0] == '0;
	endproperty
	a_edge_wrap: assert property (p_edge_wrap) // [RULE8]
		else $error("edge counter did not restart at zero");

	property p_center_turn;
		cfg[1].alignCenter && runState_reg[1] && tick && !countDown_reg[1]
			&& cnt_reg[1] == periodAct_reg[1] && periodAct_reg[1] != '0
			&& !clearPending_reg[1] |=> countDown_reg[1];
	endproperty
	a_center_turn: assert property (p_center_turn) // [RULE10]
		else $error("center counter did not turn at period");

	property p_mask;
		cfg[1].maskEn[0] && pwmSelect[1][0] |=> pinOut_reg[1][0]
			== $past(cfg[1].maskLvl[0]);
	endproperty
	a_mask: assert property (p_mask) // [RULE17]
		else $error("masked channel does not show mask level");

	property p_polarity;
		cfg[0].maskEn[2] && !brakeActive_reg && pwmSelect[0][2]
			|=> pinOut_reg[0][2]
			== ($past(cfg[0].maskLvl[2]) ^ $past(mainCfg.polarity[2]));
	endproperty
	a_polarity: assert property (p_polarity) // [RULE20]
		else $error("polarity not applied to main output");

	property p_sync;
		cfg[0].outMode == mpwm_pkg::MPWM_SYNC && cfg[0].maskEn[1:0] == 2'h0
			&& pwmSelect[0][1:0] == 2'h3 && !brakeActive_reg
			&& mainCfg.polarity[1] == mainCfg.polarity[0]
			|=> pinOut_reg[0][1] == pinOut_reg[0][0];
	endproperty
	a_sync: assert property (p_sync) // [RULE16]
		else $error("synchronous pair differs");

	property p_irq;
		brakeFlag_reg && mainCfg.brakeIrqEnable |=> brakeIrq_reg;
	endproperty
	a_irq: assert property (p_irq) // [RULE22]
		else $error("brake interrupt not raised");

	property p_flag_hold;
		periodEventFlag_reg[0] && !periodFlagClear[0]
			|=> periodEventFlag_reg[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) // [RULE21]
		else $error("period flag lost without clear");
endmodule // mpwm_top

// file: tb/mpwm_bridge_model.sv
// power stage stand-in: watches the gate pins, drives the fault line
`timescale 1ns/1ps
module mpwm_bridge_model (
	input  wire logic       clk_sys,
	input  wire logic [5:0] gate,
	input  wire logic       overCurrent,
	input  wire logic       clearFlag,
	output logic            faultPin,
	output logic            shootThrough
);
	// the sensor line has no filter of its own, so noise reaches the pin
	assign faultPin = overCurrent;
	// a pair on together would short the half bridge
	always @(posedge clk_sys) begin
		if (clearFlag)
			shootThrough <= 1'b0;
		else if ((gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5]))
			shootThrough <= 1'b1;
	end
endmodule // mpwm_bridge_model

// file: tb/tb_top.sv
// self-checking bench for the pwm generator
`timescale 1ns/1ps
module tb_top;
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	logic                  clockSource = 1'b0;
	logic [2:0]            clockPrescale = 3'h0;
	logic                  timer1Overflow = 1'b0;
	mpwm_pkg::mpwm_write_s wr = '0;
	logic [3:0]            runSet = 4'h0, runClear = 4'h0, loadSet = 4'h0;
	logic [3:0]            clearSet = 4'h0, periodFlagClear = 4'h0;
	logic                  brakeFlagClear = 1'b0;
	mpwm_pkg::mpwm_cfg_s   cfg [4];
	mpwm_pkg::mpwm_main_s  mainCfg = '0;
	logic                  deadtimeWrite = 1'b0, timedAccessUnlock = 1'b0;
	logic [8:0]            deadtimeCountIn = 9'h000;
	logic [3:0]            deadtimeEnableIn = 4'h0;
	logic                  brakeInputPin, adcCompareEvent = 1'b0;
	logic [5:0]            pwmSelect [4], gpioData [4], pinOut_reg [4];
	logic [3:0]            runState_reg, loadPending_reg, clearPending_reg;
	logic [3:0]            periodEventFlag_reg;
	logic                  brakeFlag_reg, brakeIrq_reg;
	logic                  overCurrent = 1'b0, clearFlag = 1'b1, shootThrough;
	int                    error_cnt = 0, samples_checked = 0, h, p;

	initial begin
		for (int i = 0; i < 4; i++) begin
			cfg[i] = '0;
			pwmSelect[i] = 6'h3f;
			gpioData[i] = 6'h00;
		end
	end
	always #50 clk_sys = ~clk_sys;

	mpwm_top dut_u (.clk_sys, .rst, .clockSource, .clockPrescale,
		.timer1Overflow, .wr, .runSet, .runClear, .loadSet, .clearSet,
		.periodFlagClear, .brakeFlagClear, .cfg, .mainCfg, .deadtimeWrite,
		.timedAccessUnlock, .deadtimeCountIn, .deadtimeEnableIn,
		.brakeInputPin, .adcCompareEvent, .pwmSelect, .gpioData, .pinOut_reg,
		.runState_reg, .loadPending_reg, .clearPending_reg,
		.periodEventFlag_reg, .brakeFlag_reg, .brakeIrq_reg);
	mpwm_bridge_model bridge_u (.clk_sys, .gate(pinOut_reg[0]), .overCurrent,
		.clearFlag, .faultPin(brakeInputPin), .shootThrough);

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrv(input logic [1:0] i, input logic [2:0] s,
		input logic [15:0] d);
		wr = '{1'b1, i, s, d};
		tick(1);
		wr.valid = 1'b0;
		tick(1);
	endtask
	// software must wait for the load bit to drop before touching controls
	task automatic load(input logic [1:0] i);
		int w;
		loadSet[i] = 1'b1;
		tick(1);
		loadSet = 4'h0;
		w = 0;
		while (loadPending_reg[i] !== 1'b0 && w < 100) begin
			tick(1);
			w++;
		end
		check("loadPending", loadPending_reg[i], 1'b0);
		tick(3);
	endtask
	task automatic start(input logic [1:0] i, input logic [15:0] per, d0, d1);
		clearSet[i] = 1'b1;
		tick(1);
		clearSet = 4'h0;
		check("clearPending", clearPending_reg[i], 1'b1);
		wrv(i, 3'h7, per);
		wrv(i, 3'h0, d0);
		wrv(i, 3'h1, d1);
		wrv(i, 3'h2, 16'h0005);
		load(i);
		runSet[i] = 1'b1;
		tick(1);
		runSet = 4'h0;
		check("runState", runState_reg[i], 1'b1);
		tick(6);
	endtask
	task automatic highs(input logic [1:0] i, input int c, n);
		h = 0;
		repeat (n) begin
			tick(1);
			if (pinOut_reg[i][c] === 1'b1) h++;
		end
	endtask
	// rise to rise spacing of channel 0
	task automatic period(input logic [1:0] i);
		int w;
		p = 0;
		w = 0;
		while (pinOut_reg[i][0] !== 1'b0 && w < 300) begin tick(1); w++; end
		while (pinOut_reg[i][0] !== 1'b1 && w < 300) begin tick(1); w++; end
		while (pinOut_reg[i][0] === 1'b1 && w < 300) begin tick(1); w++; p++; end
		while (pinOut_reg[i][0] !== 1'b1 && w < 300) begin tick(1); w++; p++; end
	endtask

	task automatic s_edge;
		check("pins idle", pinOut_reg[0], 6'h00);
		start(2'h0, 16'h0004, 16'h0002, 16'h0002);
		period(2'h0);
		check("edge period", p, 5);
		highs(2'h0, 0, 10);
		check("edge highs", h, 4);
		clockPrescale = 3'h1;
		tick(12);
		period(2'h0);
		check("prescaled period", p, 10);
		clockPrescale = 3'h0;
		clockSource = 1'b1;
		tick(3);
		highs(2'h0, 0, 10);
		check("stalled source", h % 10, 0);
		clockSource = 1'b0;
	endtask
	task automatic s_center;
		cfg[1].alignCenter = 1'b1;
		start(2'h1, 16'h0004, 16'h0002, 16'h0001);
		period(2'h1);
		check("center period", p, 8);
	endtask
	task automatic s_modes;
		start(2'h0, 16'h0009, 16'h0003, 16'h0005);
		highs(2'h0, 1, 10);
		check("indep ch1", h, 5);
		cfg[0].outMode = mpwm_pkg::MPWM_COMPL;
		tick(3);
		highs(2'h0, 1, 10);
		check("compl ch1", h, 7);
		cfg[0].outMode = mpwm_pkg::MPWM_SYNC;
		tick(3);
		highs(2'h0, 1, 10);
		check("sync ch1", h, 3);
		cfg[0].outMode = mpwm_pkg::MPWM_INDEP;
		cfg[0].groupMode = 1'b1;
		tick(3);
		highs(2'h0, 2, 10);
		check("group ch2", h, 3);
		highs(2'h0, 5, 10);
		check("group ch5", h, 5);
		cfg[0].groupMode = 1'b0;
	endtask
	task automatic s_buffer;
		wrv(2'h0, 3'h0, 16'h0006);
		tick(12);
		highs(2'h0, 0, 10);
		check("unloaded duty", h, 3);
		load(2'h0);
		highs(2'h0, 0, 10);
		check("loaded duty", h, 6);
	endtask
	task automatic s_output;
		mainCfg.polarity = 6'h09;
		cfg[0].maskEn = 6'h0c;
		cfg[0].maskLvl = 6'h04;
		pwmSelect[0] = 6'h2f;
		gpioData[0] = 6'h10;
		cfg[1].maskEn = 6'h01;
		cfg[1].maskLvl = 6'h01;
		tick(3);
		highs(2'h0, 0, 10);
		check("inverted ch0", h, 4);
		highs(2'h0, 2, 10);
		check("masked ch2", h, 10);
		highs(2'h0, 3, 10);
		check("masked inverted ch3", h, 10);
		highs(2'h0, 4, 10);
		check("gpio ch4", h, 10);
		highs(2'h1, 0, 10);
		check("masked inst1 ch0", h, 10);
		cfg[1].maskEn = 6'h00;
		mainCfg.polarity = 6'h00;
		cfg[0].maskEn = 6'h00;
		pwmSelect[0] = 6'h3f;
	endtask
	task automatic s_flag;
		cfg[0].eventPoint = 2'h3;
		periodFlagClear[0] = 1'b1;
		tick(1);
		periodFlagClear = 4'h0;
		tick(25);
		check("end point in edge type", periodEventFlag_reg[0], 1'b0);
		cfg[0].eventPoint = 2'h1;
		tick(12);
		check("zero point flag", periodEventFlag_reg[0], 1'b1);
	endtask
	task automatic s_deadtime;
		cfg[0].outMode = mpwm_pkg::MPWM_COMPL;
		wrv(2'h0, 3'h0, 16'h0005);
		load(2'h0);
		deadtimeCountIn = 9'h001;
		deadtimeEnableIn = 4'h1;
		deadtimeWrite = 1'b1;
		tick(1);
		deadtimeWrite = 1'b0;
		tick(3);
		highs(2'h0, 0, 10);
		check("locked dead-time", h, 5);
		deadtimeWrite = 1'b1;
		timedAccessUnlock = 1'b1;
		tick(1);
		deadtimeWrite = 1'b0;
		timedAccessUnlock = 1'b0;
		tick(3);
		clearFlag = 1'b0;
		highs(2'h0, 0, 10);
		check("dead-time ch0", h, 2);
		highs(2'h0, 1, 10);
		check("dead-time ch1", h, 2);
		check("no overlap", shootThrough, 1'b0);
		clearFlag = 1'b1;
	endtask
	task automatic s_brake;
		mainCfg = '{6'h00, 6'h2a, 1'b1, 1'b1, 1'b1};
		overCurrent = 1'b1;
		tick(5);
		overCurrent = 1'b0;
		tick(12);
		check("glitch ignored", runState_reg[0], 1'b1);
		overCurrent = 1'b1;
		tick(14);
		check("brake run", runState_reg[0], 1'b0);
		check("brake pins", pinOut_reg[0], 6'h2a);
		check("brake flag", brakeFlag_reg, 1'b1);
		check("brake irq", brakeIrq_reg, 1'b1);
		brakeFlagClear = 1'b1;
		tick(1);
		brakeFlagClear = 1'b0;
		tick(3);
		check("flag cleared", brakeFlag_reg, 1'b0);
		check("brake data held", pinOut_reg[0], 6'h2a);
		overCurrent = 1'b0;
		tick(12);
		runSet[0] = 1'b1;
		tick(1);
		runSet = 4'h0;
		check("resumed", runState_reg[0], 1'b1);
		adcCompareEvent = 1'b1;
		tick(1);
		adcCompareEvent = 1'b0;
		tick(3);
		check("adc brake", runState_reg[0], 1'b0);
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// the whole run is a few hundred cycles
	initial begin
		#(20000 * 100);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		tick(2);
		rst = 1'b0;
		tick(1);
		s_edge();
		s_center();
		s_modes();
		s_buffer();
		s_output();
		s_flag();
		s_deadtime();
		s_brake();
		tally_and_finish();
	end
endmodule // tb_top
